// ### logic/flic_ctrl.v
// four level interrupt controller with ahb-lite register slave.
// assumes one sequencer pulse per machine cycle at the late sample point,
// qualifiers from the sequencer valid in that cycle, zero wait bus.
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
`include "flic_consts.vh"

module flic_ctrl
(
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   input  wire        mc_sample,
   input  wire        instr_last,
   input  wire        instr_interrupt_return,
   input  wire        instr_cfg_write,
   input  wire        ext0_edge_mode,
   input  wire        ext1_edge_mode,
   input  wire [14:0] req_flags,
   output reg         call_req,
   output reg  [15:0] call_vector,
   output reg  [1:0]  call_level,
   output reg  [14:0] flag_clear,
   output reg  [3:0]  in_progress
);

   reg  [7:0]  enable_reg_base;
   reg  [7:0]  enable_reg_ext;
   reg  [7:0]  prio_sel_msb_ext;
   reg  [7:0]  prio_sel_lsb_ext;
   reg  [7:0]  prio_sel_msb_base;
   reg  [7:0]  prio_sel_lsb_base;
   reg  [14:0] sampled;
   reg  [3:0]  last_src;
   reg         cfg_wr_seen;
   reg         wr_pend;
   reg  [7:0]  wr_idx;
   reg  [3:0]  next_in_progress;
   reg  [14:0] next_clear;
   reg  [31:0] rd_val;

   wire [7:0]  addr_idx;
   wire        bus_take;
   wire        global_irq_enable;
   wire [14:0] src_en;
   wire [14:0] lvl_msb;
   wire [14:0] lvl_lsb;
   wire [14:0] pend;
   wire        win_valid;
   wire [3:0]  win_src;
   wire [1:0]  win_level;
   wire        busy;
   wire [1:0]  busy_level;
   wire        lvl_block;
   wire        seq_block;
   wire        take_call;
   wire [7:0]  wr_byte;

   // per-source bit from the base/ext register pair of the same layout
   function bit_of;
      input [3:0] src;
      input [7:0] base;
      input [7:0] ext;
      begin
         case (src)
            4'h0:    bit_of = base[0];
            4'h1:    bit_of = base[1];
            4'h2:    bit_of = base[2];
            4'h3:    bit_of = base[3];
            4'h4:    bit_of = base[4];
            4'h5:    bit_of = base[5];
            4'h6:    bit_of = base[6];
            4'h7:    bit_of = ext[7];
            4'h8:    bit_of = ext[1];
            4'h9:    bit_of = ext[0];
            4'ha:    bit_of = ext[2];
            4'hb:    bit_of = ext[3];
            4'hc:    bit_of = ext[4];
            4'hd:    bit_of = ext[5];
            default: bit_of = ext[6];
         endcase
      end
   endfunction

   // highest in-progress level
   function [1:0] top_level;
      input [3:0] ip;
      begin
         if (ip[3])
            top_level = 2'h3;
         else if (ip[2])
            top_level = 2'h2;
         else if (ip[1])
            top_level = 2'h1;
         else
            top_level = 2'h0;
      end
   endfunction

   // the register window is the low 1 KiB of the address space
   function addr_ok;
      input [31:0] addr;
      begin
         addr_ok = (addr[31:10] == 22'h000000);
      end
   endfunction

   // enable and priority registers; a bus write to any of them blocks one poll
   function is_cfg_idx;
      input [7:0] idx;
      begin
         case (idx)
            `FLIC_IDX_EN_EXT:    is_cfg_idx = 1'b1;
            `FLIC_IDX_EN_BASE:   is_cfg_idx = 1'b1;
            `FLIC_IDX_PMSB_EXT:  is_cfg_idx = 1'b1;
            `FLIC_IDX_PLSB_EXT:  is_cfg_idx = 1'b1;
            `FLIC_IDX_PMSB_BASE: is_cfg_idx = 1'b1;
            `FLIC_IDX_PLSB_BASE: is_cfg_idx = 1'b1;
            default:             is_cfg_idx = 1'b0;
         endcase
      end
   endfunction

   genvar g;
   generate
      for (g = 0; g < `FLIC_NSRC; g = g + 1)
      begin : map
         assign src_en[g]  = bit_of(g, enable_reg_base, enable_reg_ext);
         assign lvl_lsb[g] = bit_of(g, prio_sel_lsb_base, prio_sel_lsb_ext);
         assign lvl_msb[g] = bit_of(g, prio_sel_msb_base, prio_sel_msb_ext);
      end
   endgenerate

   assign global_irq_enable = enable_reg_base[`FLIC_GLOBAL_EN_BIT];
   // only the previous cycle's capture is polled, nothing older
   assign pend = global_irq_enable ? (sampled & src_en) : 15'h0000;

   flic_prio_pick u_pick
   (
      .pend      (pend),
      .lvl_msb   (lvl_msb),
      .lvl_lsb   (lvl_lsb),
      .win_valid (win_valid),
      .win_src   (win_src),
      .win_level (win_level)
   );

   assign busy       = |in_progress;
   assign busy_level = top_level(in_progress);
   assign lvl_block  = busy && (win_level <= busy_level);
   assign seq_block  = !instr_last || instr_interrupt_return || instr_cfg_write || cfg_wr_seen;
   // fastest path: sample, poll next cycle, call issued at its end
   assign take_call  = mc_sample && win_valid && !lvl_block && !seq_block;

   always @*
   begin
      next_in_progress = in_progress;
      // interrupt return retires the top level; a plain return has no input here
      if (mc_sample && instr_interrupt_return && instr_last)
      begin
         next_in_progress[busy_level] = 1'b0;
      end
      if (take_call)
      begin
         next_in_progress[win_level] = 1'b1;
      end
   end

   always @*
   begin
      next_clear = `FLIC_HW_CLR_MASK;
      next_clear[`FLIC_SRC_EXT0] = ext0_edge_mode;
      next_clear[`FLIC_SRC_EXT1] = ext1_edge_mode;
   end

   // interrupt sequencing
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sampled     <= 15'h0000;
         in_progress <= 4'h0;
         call_req    <= 1'b0;
         call_vector <= 16'h0000;
         call_level  <= 2'h0;
         flag_clear  <= 15'h0000;
         last_src    <= 4'h0;
      end
      else
      begin
         if (mc_sample)
         begin
            sampled <= req_flags;
         end
         in_progress <= next_in_progress;
         call_req    <= take_call;
         flag_clear  <= 15'h0000;
         if (take_call)
         begin
            call_vector <= `FLIC_VEC_BASE + ({12'h000, win_src} << 3);
            call_level  <= win_level;
            flag_clear  <= next_clear & (15'h0001 << win_src);
            last_src    <= win_src;
         end
      end
   end

   // ahb-lite slave, zero wait, always okay
   assign addr_idx = haddr[9:2];
   // write data is only valid in the data phase, one cycle after the address
   assign wr_byte  = hwdata[7:0];
   assign bus_take = hsel && hready && (htrans == `FLIC_HTRANS_NONSEQ ||
                                        htrans == `FLIC_HTRANS_SEQ);

   always @*
   begin
      rd_val = 32'h00000000;
      case (addr_idx)
         `FLIC_IDX_EN_EXT:    rd_val[7:0] = enable_reg_ext;
         `FLIC_IDX_EN_BASE:   rd_val[7:0] = enable_reg_base;
         `FLIC_IDX_PMSB_EXT:  rd_val[7:0] = prio_sel_msb_ext;
         `FLIC_IDX_PLSB_EXT:  rd_val[7:0] = prio_sel_lsb_ext;
         `FLIC_IDX_PMSB_BASE: rd_val[7:0] = prio_sel_msb_base;
         `FLIC_IDX_PLSB_BASE: rd_val[7:0] = prio_sel_lsb_base;
         `FLIC_IDX_STATUS:    rd_val[7:0] = {last_src, in_progress};
         default:             rd_val = 32'h00000000;
      endcase
      if (!addr_ok(haddr))
         rd_val = 32'h00000000;
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wr_pend   <= 1'b0;
         wr_idx    <= 8'h00;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (hready)
         begin
            wr_pend <= bus_take && hwrite && addr_ok(haddr);
            wr_idx  <= addr_idx;
         end
         if (bus_take && !hwrite)
         begin
            hrdata <= rd_val;
         end
      end
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         enable_reg_base   <= `FLIC_RST_REG;
         enable_reg_ext    <= `FLIC_RST_REG;
         prio_sel_msb_ext  <= `FLIC_RST_REG;
         prio_sel_lsb_ext  <= `FLIC_RST_REG;
         prio_sel_msb_base <= `FLIC_RST_REG;
         prio_sel_lsb_base <= `FLIC_RST_REG;
         cfg_wr_seen       <= 1'b0;
      end
      else
      begin
         if (wr_pend)
         begin
            case (wr_idx)
               `FLIC_IDX_EN_EXT:    enable_reg_ext <= wr_byte;
               `FLIC_IDX_EN_BASE:   enable_reg_base <= wr_byte;
               `FLIC_IDX_PMSB_EXT:  prio_sel_msb_ext <= wr_byte;
               `FLIC_IDX_PLSB_EXT:  prio_sel_lsb_ext <= wr_byte;
               // reserved top bit held at zero
               `FLIC_IDX_PMSB_BASE: prio_sel_msb_base <= wr_byte & `FLIC_RSVD_MASK;
               `FLIC_IDX_PLSB_BASE: prio_sel_lsb_base <= wr_byte & `FLIC_RSVD_MASK;
               default:             cfg_wr_seen <= cfg_wr_seen;
            endcase
         end
         // a bus write to enable or priority blocks the next poll; set wins
         if (wr_pend && is_cfg_idx(wr_idx))
            cfg_wr_seen <= 1'b1;
         else if (mc_sample)
            cfg_wr_seen <= 1'b0;
      end
   end

endmodule // flic_ctrl

// ### logic/flic_consts.vh
// constants for the four level interrupt controller: register indexes,
// reset values, source numbering, vector layout.
// assumes registers sit on an ahb-lite bus at byte address four times index.
// How it works
// - two selection bits per source, low in base register, high in companion
// - a running routine yields only to a strictly higher level
// - among pending requests the highest level wins
// - global enable clear blocks all; set lets each enable bit gate its source
// - flags captured at each late sample point, polled in following cycle
// - fixed fifteen-entry poll order breaks ties within one level
// - no call while equal or higher level routine is in progress
// - no call unless polling cycle is last cycle of the instruction
// - no call after interrupt return or enable or priority write
// - blocked requests are not remembered; every poll starts fresh
// - request before third-cycle sample vectors in cycles five and six
// - call pushes program counter only, no status word, loads source vector
// - vectors eight bytes apart from 0003h to 0073h in source order
// - interrupt return clears current level marker, then pops two bytes
// - plain subroutine return leaves the in-progress marker set
`ifndef FLIC_CONSTS_VH
`define FLIC_CONSTS_VH

// register indexes, byte address = index * 4
`define FLIC_IDX_EN_EXT     8'ha7
`define FLIC_IDX_EN_BASE    8'ha8
`define FLIC_IDX_PMSB_EXT   8'hb5
`define FLIC_IDX_PLSB_EXT   8'hb6
`define FLIC_IDX_PMSB_BASE  8'hb7
`define FLIC_IDX_PLSB_BASE  8'hb8
`define FLIC_IDX_STATUS     8'hc0

`define FLIC_RST_REG        8'h00
`define FLIC_RSVD_MASK      8'h7f
`define FLIC_GLOBAL_EN_BIT  7

// source numbers follow vector order
`define FLIC_NSRC           15
`define FLIC_SRC_EXT0       4'h0
`define FLIC_SRC_T0         4'h1
`define FLIC_SRC_EXT1       4'h2
`define FLIC_SRC_T1         4'h3
`define FLIC_SRC_SERIAL     4'h4
`define FLIC_SRC_T2         4'h5
`define FLIC_SRC_PCA        4'h6
`define FLIC_SRC_ADC        4'h7
`define FLIC_SRC_SECOND_CAPTURE_ARRAY       4'h8
`define FLIC_SRC_SEP        4'h9
`define FLIC_SRC_EXT2       4'ha

`define FLIC_VEC_BASE       16'h0003
`define FLIC_VEC_STEP       16'h0008

// flags cleared by hardware when their own source is called; ext0 and ext1 follow edge mode
`define FLIC_HW_CLR_MASK    15'h7c0a

`define FLIC_HTRANS_NONSEQ  2'h2
`define FLIC_HTRANS_SEQ     2'h3

`endif

// ### logic/flic_prio_pick.v
// priority resolver: highest level first, then the fixed poll order.
// assumes pending inputs are already enable gated.
`timescale 1ns/1ps
`include "flic_consts.vh"

module flic_prio_pick
(
   input  wire [14:0] pend,
   input  wire [14:0] lvl_msb,
   input  wire [14:0] lvl_lsb,
   output reg         win_valid,
   output reg  [3:0]  win_src,
   output reg  [1:0]  win_level
);

   // source number at each poll position
   function [3:0] poll_src;
      input [3:0] pos;
      begin
         case (pos)
            4'h0:    poll_src = 4'h0;
            4'h1:    poll_src = 4'h9;
            4'h2:    poll_src = 4'ha;
            4'h3:    poll_src = 4'h1;
            4'h4:    poll_src = 4'h8;
            4'h5:    poll_src = 4'hb;
            4'h6:    poll_src = 4'h2;
            4'h7:    poll_src = 4'h7;
            4'h8:    poll_src = 4'hc;
            4'h9:    poll_src = 4'h3;
            4'ha:    poll_src = 4'h6;
            4'hb:    poll_src = 4'hd;
            4'hc:    poll_src = 4'h4;
            4'hd:    poll_src = 4'h5;
            default: poll_src = 4'he;
         endcase
      end
   endfunction

   integer    lv;
   integer    ps;
   reg [3:0]  s;

   always @*
   begin
      win_valid = 1'b0;
      win_src   = 4'h0;
      win_level = 2'h0;
      s         = 4'h0;
      for (lv = 3; lv >= 0; lv = lv - 1)
      begin
         for (ps = 0; ps < `FLIC_NSRC; ps = ps + 1)
         begin
            s = poll_src(ps[3:0]);
            if (!win_valid && pend[s] && ({lvl_msb[s], lvl_lsb[s]} == lv[1:0]))
            begin
               win_valid = 1'b1;
               win_src   = s;
               win_level = lv[1:0];
            end
         end
      end
   end

endmodule // flic_prio_pick

// ### tb/flic_seq_model.sv
// sequencer model: one late sample pulse every four clocks.
// assumes the bench asks for an unfinished instruction through hold_mid.
`timescale 1ns/1ps
module flic_seq_model
(
   input  wire       hclk,
   input  wire       hresetn,
   input  wire       hold_mid,
   output reg        mc_sample,
   output reg        instr_last
);
   reg  [1:0] cnt;
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt <= 2'h0;
         mc_sample <= 1'b0;
         instr_last <= 1'b0;
      end
      else
      begin
         cnt <= cnt + 2'h1;
         mc_sample <= (cnt == 2'h3);
         instr_last <= !hold_mid;
      end
   end
endmodule // flic_seq_model

// ### tb/flic_ctrl_sva.sv
// concurrent checks on the call side of the controller.
// assumes one clock domain and the sequencer link of the top ports.
`timescale 1ns/1ps
module flic_ctrl_sva
(
   input wire        hclk,
   input wire        hresetn,
   input wire        mc_sample,
   input wire        instr_last,
   input wire        instr_interrupt_return,
   input wire        instr_cfg_write,
   input wire        call_req,
   input wire [15:0] call_vector,
   input wire [1:0]  call_level,
   input wire [14:0] flag_clear,
   input wire [3:0]  in_progress
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_poll_blocked;
      mc_sample && (!instr_last || instr_interrupt_return || instr_cfg_write);
   endsequence
   sequence s_ret_top;
      mc_sample && instr_interrupt_return && instr_last && (in_progress != 4'h0);
   endsequence
   a_call_one_pulse: assert property (
      call_req |=> !call_req) else $error("call longer than one cycle");
   a_call_after_sample: assert property (
      call_req |-> $past(mc_sample)) else $error("call without sample");
   a_blocked_no_call: assert property (
      s_poll_blocked |=> !call_req) else $error("call while blocked");
   a_vec_layout: assert property (
      call_req |-> call_vector[2:0] == 3'h3 && call_vector <= 16'h0073)
      else $error("vector off grid");
   a_level_marked: assert property (
      call_req |-> in_progress[call_level]) else $error("level not marked");
   a_preempt_higher: assert property (
      call_req |-> ($past(in_progress) >> call_level) == 4'h0)
      else $error("call over equal or higher level");
   a_clear_with_call: assert property (
      flag_clear != 15'h0 |-> call_req && $onehot(flag_clear))
      else $error("flag clear outside call");
   a_interrupt_return_drops: assert property (
      s_ret_top |=> in_progress < $past(in_progress)) else $error("return kept level");
endmodule // flic_ctrl_sva

bind flic_ctrl flic_ctrl_sva u_sva (.hclk, .hresetn, .mc_sample, .instr_last, .instr_interrupt_return,
   .instr_cfg_write, .call_req, .call_vector, .call_level, .flag_clear, .in_progress);

// ### tb/tb_four_level_irq_controller.sv
// self-checking bench for the interrupt controller.
// assumes the sequencer model drives sample pulses and instruction ends.
`timescale 1ns/1ps
`include "flic_consts.vh"
module tb_four_level_irq_controller;
   reg         hclk, hresetn, hsel, hwrite, hold_mid, instr_interrupt_return, instr_cfg_write;
   reg         ext0_edge_mode, ext1_edge_mode;
   reg  [31:0] haddr, hwdata, q;
   reg  [1:0]  htrans;
   reg  [14:0] req_flags;
   reg  [18:0] rows [0:20];
   wire [31:0] hrdata;
   wire        hreadyout, hresp, mc_sample, instr_last, call_req;
   wire [15:0] call_vector;
   wire [1:0]  call_level;
   wire [14:0] flag_clear;
   wire [3:0]  in_progress;
   integer     failures, total_checks, i;

   flic_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mc_sample(mc_sample),
      .instr_last(instr_last), .instr_interrupt_return(instr_interrupt_return), .instr_cfg_write(instr_cfg_write),
      .ext0_edge_mode(ext0_edge_mode), .ext1_edge_mode(ext1_edge_mode),
      .req_flags(req_flags), .call_req(call_req), .call_vector(call_vector),
      .call_level(call_level), .flag_clear(flag_clear), .in_progress(in_progress));
   flic_seq_model u_seq (.hclk(hclk), .hresetn(hresetn), .hold_mid(hold_mid),
      .mc_sample(mc_sample), .instr_last(instr_last));

   initial
   begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   task end_sim;
   begin
      if (failures == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   end
   endtask

   task chk(input [31:0] seen, input [31:0] exp, input [8*8-1:0] nm);
   begin
      total_checks = total_checks + 1;
      if (seen !== exp)
      begin
         failures = failures + 1;
         $display("[FAIL] %0s expected %h seen %h", nm, exp, seen);
      end
   end
   endtask

   // waits up to n edges for a high flag sampled at the edge
   task wfor(input integer sel, input integer n);
      integer k;
   begin
      k = 0;
      do
      begin
         @(posedge hclk);
         k = k + 1;
      end while ((sel == 0 ? hreadyout : sel == 1 ? call_req : mc_sample) !== 1'b1 && k < n);
      if (k >= n)
      begin
         chk(0, 1, "timeout");
         end_sim;
      end
   end
   endtask

   task bus(input w, input [7:0] idx, input [7:0] d);
   begin
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {22'h0, idx, 2'h0};
      wfor(0, 20);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      wfor(0, 20);
      q = hrdata;
      chk(hresp, 0, "hresp");
   end
   endtask

   task wcall(input [15:0] vec, input [1:0] lvl);
   begin
      wfor(1, 60);
      chk(call_vector, vec, "vector");
      chk(call_level, lvl, "level");
   end
   endtask

   task nocall;
      integer c;
   begin
      c = 0;
      repeat (16)
      begin
         @(posedge hclk);
         if (call_req !== 1'b0)
            c = 1;
      end
      chk(c, 0, "nocall");
   end
   endtask

   task interrupt_return;
   begin
      @(posedge hclk);
      instr_interrupt_return <= 1'b1;
      wfor(2, 8);
      instr_interrupt_return <= 1'b0;
      @(posedge hclk);
   end
   endtask

   initial
   begin
      {hresetn, hsel, hwrite, hold_mid, instr_interrupt_return, instr_cfg_write} = 6'h0;
      {ext0_edge_mode, ext1_edge_mode, htrans, req_flags} = 19'h0;
      haddr = 32'h0;
      hwdata = 32'h0;
      failures = 0;
      total_checks = 0;
      for (i = 0; i < 15; i = i + 1)
         rows[i] = {15'h1 << i, i[3:0]};
      rows[15] = {15'h7fff, 4'h0};
      rows[16] = {15'h7ffe, 4'h9};
      rows[17] = {15'h00fe, 4'h1};
      rows[18] = {15'h00ec, 4'h2};
      rows[19] = {15'h0078, 4'h3};
      rows[20] = {15'h0030, 4'h4};
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      for (i = 8'hb5; i < 8'hb9; i = i + 1)
      begin
         bus(0, i[7:0], 8'h0);
         chk(q, 0, "prio rst");
      end
      bus(1, `FLIC_IDX_PLSB_EXT, 8'h5a);
      bus(0, `FLIC_IDX_PLSB_EXT, 8'h0);
      chk(q, 32'h5a, "prio rw");
      // back to level zero so every table row resolves at the lowest level
      bus(1, `FLIC_IDX_PLSB_EXT, 8'h00);
      bus(0, 8'h10, 8'h0);
      chk(q, 0, "unmapped");
      bus(1, `FLIC_IDX_EN_BASE, 8'hff);
      bus(1, `FLIC_IDX_EN_EXT, 8'hff);
      ext0_edge_mode <= 1'b1;
      ext1_edge_mode <= 1'b1;
      for (i = 0; i < 21; i = i + 1)
      begin
         req_flags <= rows[i][18:4];
         wcall(16'h0003 + {rows[i][3:0], 3'h0}, 2'h0);
         chk(flag_clear, 15'h7c0f & (15'h1 << rows[i][3:0]), "clear");
         chk(in_progress, 4'h1, "progress");
         req_flags <= 15'h0;
         interrupt_return;
         chk(in_progress, 4'h0, "return");
      end
      // bit 7 of the base priority registers is never written as one
      bus(1, `FLIC_IDX_PLSB_BASE, 8'h02);
      req_flags <= 15'h3;
      wcall(16'h000b, 2'h1);
      req_flags <= 15'h0;
      interrupt_return;
      bus(1, `FLIC_IDX_PLSB_BASE, 8'h03);
      req_flags <= 15'h2;
      wcall(16'h000b, 2'h1);
      req_flags <= 15'h1;
      nocall;
      bus(1, `FLIC_IDX_PMSB_BASE, 8'h01);
      wcall(16'h0003, 2'h3);
      chk(in_progress, 4'ha, "nested");
      req_flags <= 15'h0;
      interrupt_return;
      chk(in_progress, 4'h2, "ret top");
      interrupt_return;
      bus(1, `FLIC_IDX_PMSB_BASE, 8'h00);
      bus(1, `FLIC_IDX_PLSB_BASE, 8'h00);
      hold_mid <= 1'b1;
      req_flags <= 15'h4;
      nocall;
      // let one capture see the flag low before the block lifts
      req_flags <= 15'h0;
      wfor(2, 8);
      hold_mid <= 1'b0;
      nocall;
      req_flags <= 15'h4;
      instr_cfg_write <= 1'b1;
      nocall;
      instr_cfg_write <= 1'b0;
      instr_interrupt_return <= 1'b1;
      nocall;
      // global disable lands while the return still blocks the poll
      bus(1, `FLIC_IDX_EN_BASE, 8'h7f);
      instr_interrupt_return <= 1'b0;
      nocall;
      ext1_edge_mode <= 1'b0;
      bus(1, `FLIC_IDX_EN_BASE, 8'hff);
      wcall(16'h0013, 2'h0);
      chk(flag_clear, 15'h0, "level");
      req_flags <= 15'h0;
      bus(0, `FLIC_IDX_STATUS, 8'h0);
      chk(q, 32'h21, "status");
      // reset in mid-run with a level in progress and the enables set
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      chk(hrdata, 0, "rst data");
      chk({hresp, hreadyout, call_req, call_level, flag_clear}, 32'h40000, "rst flag");
      chk({call_vector, in_progress}, 0, "rst call");
      hresetn <= 1'b1;
      bus(0, `FLIC_IDX_EN_BASE, 8'h0);
      chk(q, 0, "rst en");
      end_sim;
   end
endmodule // tb_four_level_irq_controller
